/* logic/mse_exec.sv */
// Execution unit for halt, register/immediate subtract, nibble swap, table read.
// Assumes decoder pulses op_valid_in for one cycle while ready_out is high.
// Overview of operation
// RQ1 - Halt clears watchdog counter and its prescaler to zero
// RQ2 - Halt sets time-out flag, clears power-down flag, enters halt mode
// RQ3 - Register minus accumulator, updates zero, digit-carry, carry; register 0..63
// RQ4 - Destination bit 0 writes accumulator, 1 writes source register
// RQ5 - Swap exchanges nibbles, writes per destination, flags untouched
// RQ6 - Immediate minus accumulator into accumulator, updates zero, digit-carry, carry
// RQ7 - Table address is pointer bits 2..0 above accumulator; low byte to accumulator
// RQ8 - Fetched word bits 13..8 go to table high data bits 5..0
// RQ9 - Carry is inverted borrow; zero set on zero result
// RQ10 - Table read takes two cycles, others one
module mse_exec (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rstn_in,
	// Decoded instruction
	input wire logic op_valid_in,
	input wire logic [2:0] op_code_in,
	input wire logic [5:0] reg_addr_in,
	input wire logic dest_bit_in,
	input wire logic [7:0] imm_in,
	input wire logic [7:0] reg_rdata_in,
	input wire logic [7:0] table_high_pointer_in,
	output logic ready_out,
	// Register file write
	output logic reg_we_out,
	output logic [5:0] reg_waddr_out,
	output logic [7:0] reg_wdata_out,
	// Program memory
	output logic rom_re_out,
	output logic [10:0] rom_addr_out,
	input wire logic [13:0] rom_data_in,
	// Architectural state
	output logic [7:0] accumulator_out,
	output logic [5:0] table_high_data_out,
	output logic zero_flag_out,
	output logic digit_carry_flag_out,
	output logic carry_flag_out,
	output logic time_out_flag_out,
	output logic power_down_flag_out,
	output logic halt_mode_out,
	// Watchdog clear
	output logic wdt_clear_out,
	output logic [7:0] watchdog_counter_load_out,
	output logic [7:0] watchdog_prescaler_load_out
);
	////////////////////////////////////////////////////////////////////////
	logic [7:0] acc_reg;
	logic [5:0] thd_reg;
	logic z_reg, dc_reg, c_reg, to_reg, pd_reg, halt_reg;
	logic we_reg, rre_reg, wclr_reg;
	logic [5:0] waddr_reg;
	logic [7:0] wdata_reg;
	logic [10:0] raddr_reg;
	mse_pkg::mse_state_type state_reg;
	logic [7:0] sub_a, sub_d;
	logic sub_z, sub_dc, sub_c, go;
	logic [7:0] swapped;

	// Taken op of one kind
	function automatic logic takes(input logic taken, input logic [2:0] code,
		input logic [2:0] kind);
		return taken && (code == kind);
	endfunction

	assign go = op_valid_in && (state_reg == mse_pkg::MSE_ST_IDLE);
	assign ready_out = (state_reg == mse_pkg::MSE_ST_IDLE);
	assign swapped = {reg_rdata_in[3:0], reg_rdata_in[7:4]}; // RQ5
	always_comb begin
		sub_a = (op_code_in == mse_pkg::MSE_OP_SUBI) ? imm_in : reg_rdata_in; // RQ3 RQ6
	end

	mse_sub8 u_sub (
		.minuend_in(sub_a),
		.subtrahend_in(acc_reg),
		.diff_out(sub_d),
		.zero_out(sub_z),
		.digit_carry_out(sub_dc),
		.carry_out(sub_c)
	);

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_reg <= mse_pkg::MSE_ST_IDLE;
		end else if (takes(go, op_code_in, mse_pkg::MSE_OP_TABLE)) begin
			state_reg <= mse_pkg::MSE_ST_FETCH; // RQ10
		end else begin
			state_reg <= mse_pkg::MSE_ST_IDLE; // RQ10
		end
	end

	// Program memory request
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rre_reg <= 1'b0;
			raddr_reg <= 11'h000;
		end else begin
			rre_reg <= takes(go, op_code_in, mse_pkg::MSE_OP_TABLE); // RQ10
			if (takes(go, op_code_in, mse_pkg::MSE_OP_TABLE)) begin
				raddr_reg <= {table_high_pointer_in[2:0], acc_reg}; // RQ7
			end
		end
	end

	// Accumulator and table high data
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			acc_reg <= 8'h00;
			thd_reg <= 6'h00;
		end else if (state_reg == mse_pkg::MSE_ST_FETCH) begin
			acc_reg <= rom_data_in[7:0]; // RQ7
			thd_reg <= rom_data_in[13:mse_pkg::MSE_HD_LSB]; // RQ8
		end else if (go) begin
			case (op_code_in)
				mse_pkg::MSE_OP_SUBR: begin
					if (!dest_bit_in) acc_reg <= sub_d; // RQ4
				end
				mse_pkg::MSE_OP_SUBI: begin
					acc_reg <= sub_d; // RQ6
				end
				mse_pkg::MSE_OP_SWAP: begin
					if (!dest_bit_in) acc_reg <= swapped; // RQ5
				end
				default: begin
				end
			endcase
		end
	end

	// Register write-back
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			we_reg <= 1'b0;
			waddr_reg <= 6'h00;
			wdata_reg <= 8'h00;
		end else begin
			we_reg <= go && dest_bit_in && (op_code_in == mse_pkg::MSE_OP_SUBR ||
				op_code_in == mse_pkg::MSE_OP_SWAP); // RQ4 RQ5
			if (go) begin
				waddr_reg <= reg_addr_in; // RQ3
				wdata_reg <= (op_code_in == mse_pkg::MSE_OP_SWAP) ? swapped : sub_d;
			end
		end
	end

	// Arithmetic flags
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			z_reg <= 1'b0;
			dc_reg <= 1'b0;
			c_reg <= 1'b0;
		end else if (go && (op_code_in == mse_pkg::MSE_OP_SUBR ||
			op_code_in == mse_pkg::MSE_OP_SUBI)) begin
			z_reg <= sub_z; // RQ9
			dc_reg <= sub_dc; // RQ3
			c_reg <= sub_c; // RQ9
		end
	end

	// Halt entry
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			to_reg <= 1'b1;
			pd_reg <= 1'b1;
			halt_reg <= 1'b0;
			wclr_reg <= 1'b0;
		end else begin
			wclr_reg <= takes(go, op_code_in, mse_pkg::MSE_OP_HALT); // RQ1
			if (takes(go, op_code_in, mse_pkg::MSE_OP_HALT)) begin
				to_reg <= 1'b1; // RQ2
				pd_reg <= 1'b0; // RQ2
				halt_reg <= 1'b1; // RQ2
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign accumulator_out = acc_reg;
	assign table_high_data_out = thd_reg;
	assign zero_flag_out = z_reg;
	assign digit_carry_flag_out = dc_reg;
	assign carry_flag_out = c_reg;
	assign time_out_flag_out = to_reg;
	assign power_down_flag_out = pd_reg;
	assign halt_mode_out = halt_reg;
	assign reg_we_out = we_reg;
	assign reg_waddr_out = waddr_reg;
	assign reg_wdata_out = wdata_reg;
	assign rom_re_out = rre_reg;
	assign rom_addr_out = raddr_reg;
	assign wdt_clear_out = wclr_reg;
	assign watchdog_counter_load_out = mse_pkg::MSE_WDT_CLEAR;
	assign watchdog_prescaler_load_out = mse_pkg::MSE_PRESC_CLEAR;

	////////////////////////////////////////////////////////////////////////
	sequence s_table_issue;
		go && op_code_in == mse_pkg::MSE_OP_TABLE;
	endsequence
	sequence s_table_done;
		rom_re_out && !ready_out;
	endsequence

	chk_table_two_cycles: assert property (@(posedge mclk_in) disable iff (!rstn_in) // RQ10
		s_table_issue |=> s_table_done ##1 ready_out)
		else $error("table read not two cycles");
	chk_table_addr: assert property (@(posedge mclk_in) disable iff (!rstn_in) // RQ7
		s_table_issue |=> rom_addr_out == {$past(table_high_pointer_in[2:0]), $past(acc_reg)})
		else $error("table address wrong");
	chk_table_load: assert property (@(posedge mclk_in) disable iff (!rstn_in) // RQ8
		s_table_done |=> table_high_data_out == $past(rom_data_in[13:8])
		&& accumulator_out == $past(rom_data_in[7:0]))
		else $error("table data not loaded");
	chk_halt_flags: assert property (@(posedge mclk_in) disable iff (!rstn_in) // RQ2
		go && op_code_in == mse_pkg::MSE_OP_HALT |=> time_out_flag_out && !power_down_flag_out
		&& halt_mode_out && $stable(carry_flag_out) && $stable(zero_flag_out)
		&& $stable(digit_carry_flag_out))
		else $error("halt flags wrong");
	chk_halt_wdt: assert property (@(posedge mclk_in) disable iff (!rstn_in) // RQ1
		go && op_code_in == mse_pkg::MSE_OP_HALT |=> wdt_clear_out
		&& watchdog_counter_load_out == 8'h00 && watchdog_prescaler_load_out == 8'h00)
		else $error("watchdog not cleared");
	chk_subi_result: assert property (@(posedge mclk_in) disable iff (!rstn_in) // RQ6
		go && op_code_in == mse_pkg::MSE_OP_SUBI |=>
		accumulator_out == 8'($past(imm_in) - $past(acc_reg)))
		else $error("immediate subtract wrong");
	chk_sub_carry: assert property (@(posedge mclk_in) disable iff (!rstn_in) // RQ9
		go && op_code_in == mse_pkg::MSE_OP_SUBR |=>
		carry_flag_out == ($past(reg_rdata_in) >= $past(acc_reg))
		&& zero_flag_out == ($past(reg_rdata_in) == $past(acc_reg)))
		else $error("borrow or zero wrong");
	chk_subr_dest: assert property (@(posedge mclk_in) disable iff (!rstn_in) // RQ4
		go && op_code_in == mse_pkg::MSE_OP_SUBR && dest_bit_in |=>
		reg_we_out && $stable(accumulator_out) && reg_waddr_out == $past(reg_addr_in))
		else $error("subtract destination wrong");
	chk_swap_flags: assert property (@(posedge mclk_in) disable iff (!rstn_in) // RQ5
		go && op_code_in == mse_pkg::MSE_OP_SWAP |=> $stable(carry_flag_out)
		&& $stable(digit_carry_flag_out) && $stable(zero_flag_out)
		&& ($past(dest_bit_in) ? reg_wdata_out : accumulator_out)
		== {$past(reg_rdata_in[3:0]), $past(reg_rdata_in[7:4])})
		else $error("swap wrong");
	chk_subr_dc: assert property (@(posedge mclk_in) disable iff (!rstn_in) // RQ3
		go && op_code_in == mse_pkg::MSE_OP_SUBR |=>
		digit_carry_flag_out == ($past(reg_rdata_in[3:0]) >= $past(acc_reg[3:0])))
		else $error("digit carry wrong");
endmodule

/* logic/mse_pkg.sv */
// Package of constants for the sub/swap/table/halt execution unit.
// Assumes a single instruction clock and a one-cycle program memory read.
package mse_pkg;
	localparam logic [7:0] MSE_WDT_CLEAR = 8'h00;
	localparam logic [7:0] MSE_PRESC_CLEAR = 8'h00;
	localparam int MSE_REG_AW = 6;
	localparam int MSE_ROM_AW = 11;
	localparam int MSE_ROM_DW = 14;
	localparam int MSE_HP_LSB_W = 3;
	localparam int MSE_HD_W = 6;
	localparam int MSE_HD_LSB = 8;
	localparam logic [2:0] MSE_OP_NONE = 3'h0;
	localparam logic [2:0] MSE_OP_HALT = 3'h1;
	localparam logic [2:0] MSE_OP_SUBR = 3'h2;
	localparam logic [2:0] MSE_OP_SUBI = 3'h3;
	localparam logic [2:0] MSE_OP_SWAP = 3'h4;
	localparam logic [2:0] MSE_OP_TABLE = 3'h5;
	typedef enum logic [0:0] {
		MSE_ST_IDLE = 1'b0,
		MSE_ST_FETCH = 1'b1
	} mse_state_type;
endpackage

/* logic/mse_sub8.sv */
// Two's complement 8-bit subtractor with zero, digit-carry and carry.
// Assumes caller gates flag writes by opcode.
module mse_sub8 (
	// Operands
	input wire logic [7:0] minuend_in,
	input wire logic [7:0] subtrahend_in,
	// Result
	output logic [7:0] diff_out,
	output logic zero_out,
	output logic digit_carry_out,
	output logic carry_out
);
	logic [8:0] full_sum;
	logic [4:0] low_sum;
	always_comb begin
		full_sum = {1'b0, minuend_in} + {1'b0, ~subtrahend_in} + 9'h001;
		low_sum = {1'b0, minuend_in[3:0]} + {1'b0, ~subtrahend_in[3:0]} + 5'h01;
		diff_out = full_sum[7:0];
		zero_out = (full_sum[7:0] == 8'h00);
		digit_carry_out = low_sum[4];
		carry_out = full_sum[8];
	end
endmodule

/* tb/mse_rom_model.sv */
// Program memory model for the execution unit bench.
// Assumes data is needed only while the read strobe is high.
module mse_rom_model (
	// Read port
	input wire logic mclk_in,
	input wire logic re_in,
	input wire logic [10:0] addr_in,
	output logic [13:0] data_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [13:0] junk_reg = 14'h2aaa;
	function automatic logic [13:0] word(input logic [10:0] a);
		return {a[10:5], a[7:0]} ^ 14'h1a5c;
	endfunction
	// Changing junk outside reads
	always @(posedge mclk_in) junk_reg <= ~junk_reg + 14'h0013;
	assign data_out = re_in ? word(addr_in) : junk_reg;
endmodule

/* tb/mse_exec_tb.sv */
// Self-checking bench for the execution unit.
// Assumes the program memory model in mse_rom_model.sv.
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin error_cnt++; \
	$display("BAD %s exp %h got %h", nm, e, s); end end
module mse_exec_tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [23:0] st; logic [15:0] aux; int due;} mse_note_type;
	logic mclk_in = 1'b0, rstn_in = 1'b0, op_valid_in = 1'b0, dest_bit_in = 1'b0;
	logic [2:0] op_code_in = 3'h0;
	logic [5:0] reg_addr_in = 6'h00;
	logic [7:0] imm_in = 8'h00, reg_rdata_in = 8'h00, table_high_pointer_in = 8'h00;
	logic ready_out, reg_we_out, rom_re_out, zero_flag_out, digit_carry_flag_out;
	logic carry_flag_out, time_out_flag_out, power_down_flag_out, halt_mode_out;
	logic wdt_clear_out;
	logic [5:0] reg_waddr_out, table_high_data_out, thd;
	logic [7:0] reg_wdata_out, accumulator_out, acc, res, a;
	logic [7:0] watchdog_counter_load_out, watchdog_prescaler_load_out;
	logic [10:0] rom_addr_out;
	logic [13:0] rom_data_in, w;
	logic [2:0] fl, pw;
	logic [23:0] seen;
	logic [15:0] aux;
	mse_note_type q[$];
	int cyc = 0, error_cnt = 0, compares = 0;
	always #50 mclk_in = ~mclk_in;
	mse_exec i_dut (.mclk_in, .rstn_in, .op_valid_in, .op_code_in, .reg_addr_in,
		.dest_bit_in, .imm_in, .reg_rdata_in, .table_high_pointer_in, .ready_out,
		.reg_we_out, .reg_waddr_out, .reg_wdata_out, .rom_re_out, .rom_addr_out,
		.rom_data_in, .accumulator_out, .table_high_data_out, .zero_flag_out,
		.digit_carry_flag_out, .carry_flag_out, .time_out_flag_out, .power_down_flag_out,
		.halt_mode_out, .wdt_clear_out, .watchdog_counter_load_out,
		.watchdog_prescaler_load_out);
	mse_rom_model i_rom (.mclk_in(mclk_in), .re_in(rom_re_out), .addr_in(rom_addr_out),
		.data_out(rom_data_in));
	assign seen = {ready_out, accumulator_out, table_high_data_out, zero_flag_out,
		digit_carry_flag_out, carry_flag_out, time_out_flag_out, power_down_flag_out,
		halt_mode_out, reg_we_out, rom_re_out, wdt_clear_out};
	assign aux = reg_we_out ? {2'h0, reg_waddr_out, reg_wdata_out} : rom_re_out ?
		{5'h00, rom_addr_out} : {watchdog_counter_load_out, watchdog_prescaler_load_out};
	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic note(input int d, input logic [2:0] p, input logic r, input logic [15:0] x);
		q.push_back('{{r, acc, thd, fl, pw, p}, x, cyc + d});
	endtask
	task automatic reset_state();
		acc = 8'h00;
		thd = 6'h00;
		fl = 3'h0;
		pw = 3'b110;
		note(0, 3'b000, 1'b1, 16'h0000);
	endtask
	// Issue one op at the falling edge; eq forces a zero result
	task automatic issue(input logic [2:0] op, input logic eq);
		int k;
		@(negedge mclk_in);
		for (k = 0; k < 8 && ready_out !== 1'b1; k++) @(negedge mclk_in);
		if (k == 8) begin
			error_cnt++;
			close_out();
		end
		op_valid_in = 1'b1;
		op_code_in = op;
		reg_addr_in = 6'($urandom);
		dest_bit_in = 1'($urandom);
		imm_in = eq ? acc : 8'($urandom % 255);
		reg_rdata_in = eq ? acc : 8'($urandom);
		table_high_pointer_in = 8'($urandom);
		a = (op == mse_pkg::MSE_OP_SUBI) ? imm_in : reg_rdata_in;
		res = (op == mse_pkg::MSE_OP_SWAP) ? {a[3:0], a[7:4]} : a - acc;
		if (op == mse_pkg::MSE_OP_SUBR || op == mse_pkg::MSE_OP_SUBI)
			fl = {res == 8'h00, a[3:0] >= acc[3:0], a >= acc};
		if (op == mse_pkg::MSE_OP_HALT) begin
			pw = 3'b101;
			note(1, 3'b001, 1'b1, 16'h0000);
		end else if (op == mse_pkg::MSE_OP_TABLE) begin
			w = i_rom.word({table_high_pointer_in[2:0], acc});
			note(1, 3'b010, 1'b0, {5'h00, table_high_pointer_in[2:0], acc});
			acc = w[7:0];
			thd = w[13:8];
			note(2, 3'b000, 1'b1, 16'h0000);
			@(negedge mclk_in);
			// Refused while busy
			op_code_in = mse_pkg::MSE_OP_SUBI;
		end else if (op != mse_pkg::MSE_OP_SUBI && dest_bit_in)
			note(1, 3'b100, 1'b1, {2'h0, reg_addr_in, res});
		else begin
			acc = res;
			note(1, 3'b000, 1'b1, 16'h0000);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge mclk_in) begin
		while (q.size() > 0 && q[0].due == cyc) begin
			`CHK("state", q[0].st, seen)
			`CHK("aux", q[0].aux, aux)
			void'(q.pop_front());
		end
		cyc++;
	end
	initial begin
		void'($urandom(56964));
		repeat (20) @(negedge mclk_in);
		rstn_in = 1'b1;
		reset_state();
		$display("test reset done");
		for (int i = 0; i < 80; i++)
			issue(3'(mse_pkg::MSE_OP_SUBR + $urandom % 4), 1'b0);
		$display("test random ops done");
		issue(mse_pkg::MSE_OP_SUBI, 1'b1);
		issue(mse_pkg::MSE_OP_SUBR, 1'b1);
		$display("test zero result done");
		issue(mse_pkg::MSE_OP_HALT, 1'b0);
		@(negedge mclk_in);
		op_valid_in = 1'b0;
		$display("test halt done");
		@(negedge mclk_in);
		rstn_in = 1'b0;
		repeat (2) @(negedge mclk_in);
		rstn_in = 1'b1;
		reset_state();
		issue(mse_pkg::MSE_OP_SUBI, 1'b0);
		@(negedge mclk_in);
		op_valid_in = 1'b0;
		repeat (3) @(negedge mclk_in);
		$display("test second reset done");
		if (q.size() != 0)
			error_cnt++;
		close_out();
	end
endmodule
